// >>> common/sdp_pkg.sv
// Constants shared by the shared data bus I/O port and its pin synchroniser.
// Assumes a 32-bit APB slave whose register word index is the byte address divided by four.
`default_nettype none

package sdp_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned PORT_W   = 8;
    localparam int unsigned MODE_W   = 2;
    localparam int unsigned PADDR_W  = 18;
    localparam int unsigned PDATA_W  = 32;
    localparam int unsigned SYNC_W   = PORT_W + MODE_W + 1;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] IDX_PCR  = 16'hFFAE;
    localparam logic [15:0] IDX_DDR  = 16'hFFB4;
    localparam logic [15:0] IDX_DR   = 16'hFFB6;
    localparam logic [15:0] IDX_STAT = 16'hFFBC;

    localparam logic [PADDR_W-1:0] ADDR_PCR  = {IDX_PCR, 2'h0};
    localparam logic [PADDR_W-1:0] ADDR_DDR  = {IDX_DDR, 2'h0};
    localparam logic [PADDR_W-1:0] ADDR_DR   = {IDX_DR, 2'h0};
    localparam logic [PADDR_W-1:0] ADDR_STAT = {IDX_STAT, 2'h0};

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [PORT_W-1:0] RST_PCR = 8'h00;
    localparam logic [PORT_W-1:0] RST_DDR = 8'h00;
    localparam logic [PORT_W-1:0] RST_DR  = 8'h00;

    // ------------------------------------------------------------------
    // Operating modes and status fields
    // ------------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_SINGLE = 2'h3;

    localparam int unsigned STAT_MODE_LSB = 0;
    localparam int unsigned STAT_SWSB_BIT = 2;
    localparam int unsigned STAT_HWSB_BIT = 3;
    localparam int unsigned STAT_SNGL_BIT = 4;

    // ------------------------------------------------------------------
    // Synchroniser field positions
    // ------------------------------------------------------------------
    localparam int unsigned SYNC_PIN_LSB  = 0;
    localparam int unsigned SYNC_MODE_LSB = PORT_W;
    localparam int unsigned SYNC_HWSB_BIT = PORT_W + MODE_W;

endpackage

`default_nettype wire

// >>> common/sdp_sync_if.sv
// Carrier between the port core and its input synchroniser.
// Assumes raw levels come from pins outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

interface sdp_sync_if #(
    parameter int unsigned W = 11
);
    logic [W-1:0] raw;
    logic [W-1:0] q;

    modport sync (input raw, output q);
    modport user (output raw, input q);
endinterface

`default_nettype wire

// >>> src/sdp_pin_sync.sv
// Two-stage synchroniser for every asynchronous level that the port reads.
// Assumes one clock; the first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module sdp_pin_sync #(
    parameter int unsigned W = 11
) (
    input  wire logic pclk,
    input  wire logic presetn,
    sdp_sync_if.sync  sif
);
    import sdp_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sdp_sync_state_t;

    sdp_sync_state_t st_r;
    sdp_sync_state_t st_nxt;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = sif.raw;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign sif.q = st_r.s2;

endmodule

`default_nettype wire

// >>> src/sdp_port.sv
// Eight-bit I/O port whose pins double as the external data bus, with APB registers.
// Assumes a 32-bit APB master on pclk, mode straps and a hardware standby pin from outside,
// and a software standby level and bus drive signals from logic on the same clock.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - A direction bit of one makes its pin an output, zero an input.
// - Direction register is write-only at its own address and resets to zero.
// - Data register is readable and writable, one output value per pin.
// - Data reads give latched value for outputs, live pin level for inputs.
// - Pull-up control register is eight bits, readable and writable, resets to zero.
// - A pull-up is on only when its control bit is one and direction zero.
// - Every bit has its own independently switched pull-up control.
// - Pull-ups work only in single-chip mode; in expanded modes always off.
// - In expanded modes pins are the data bus; port registers are ignored.
// - In single-chip mode pins are general I/O under port register control.
// - Reset or hardware standby clears registers; pins float with pull-ups off.
// - During software standby the port registers keep their contents.
// - Software standby in expanded modes floats every pin as data input.
// - Software standby in single-chip mode keeps pin states and pull-ups.
module sdp_port (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [sdp_pkg::PADDR_W-1:0]   paddr,
    input  wire logic [sdp_pkg::PDATA_W-1:0]   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [sdp_pkg::PDATA_W-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [sdp_pkg::MODE_W-1:0]    mode_pins,
    input  wire logic                          hw_standby_n,
    input  wire logic                          sw_standby,
    input  wire logic [sdp_pkg::PORT_W-1:0]    bus_dout,
    input  wire logic                          bus_doe,
    output logic      [sdp_pkg::PORT_W-1:0]    bus_din,
    input  wire logic [sdp_pkg::PORT_W-1:0]    pin_in,
    output logic      [sdp_pkg::PORT_W-1:0]    pin_out,
    output logic      [sdp_pkg::PORT_W-1:0]    pin_oe,
    output logic      [sdp_pkg::PORT_W-1:0]    pin_pullup
);
    import sdp_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PORT_W-1:0] ddr;
        logic [PORT_W-1:0] dr;
        logic [PORT_W-1:0] pcr;
        logic              single;
        logic              hwsb;
        logic              swsb;
        logic              pready;
        logic              pslverr;
        logic [PORT_W-1:0] prdata;
        logic [PORT_W-1:0] pin_out;
        logic [PORT_W-1:0] pin_oe;
        logic [PORT_W-1:0] pin_pu;
    } sdp_port_state_t;

    localparam sdp_port_state_t ST_RST = '{
        ddr:     RST_DDR,
        dr:      RST_DR,
        pcr:     RST_PCR,
        default: '0
    };

    sdp_port_state_t st_r;
    sdp_port_state_t st_nxt;

    logic [PORT_W-1:0] pin_q;
    logic [MODE_W-1:0] mode_q;
    logic              hw_q;
    logic              setup_cyc;
    logic              wr_en;
    logic              hit_pcr;
    logic              hit_ddr;
    logic              hit_dr;
    logic              hit_stat;
    logic [PORT_W-1:0] dr_view;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    sdp_sync_if #(.W(SYNC_W)) sif ();

    assign sif.raw = {~hw_standby_n, mode_pins, pin_in};

    sdp_pin_sync #(
        .W (SYNC_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif)
    );

    assign pin_q  = sif.q[SYNC_PIN_LSB +: PORT_W];
    assign mode_q = sif.q[SYNC_MODE_LSB +: MODE_W];
    assign hw_q   = sif.q[SYNC_HWSB_BIT];

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign hit_pcr   = (paddr == ADDR_PCR);
    assign hit_ddr   = (paddr == ADDR_DDR);
    assign hit_dr    = (paddr == ADDR_DR);
    assign hit_stat  = (paddr == ADDR_STAT);
    assign setup_cyc = psel && !penable;
    assign wr_en     = psel && penable && st_r.pready && pwrite && pstrb[0] && !st_r.swsb;
    assign dr_view   = (st_r.ddr & st_r.dr) | (~st_r.ddr & pin_q);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.single  = (mode_q == MODE_SINGLE);
        st_nxt.hwsb    = hw_q;
        st_nxt.swsb    = sw_standby;
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;

        if (hw_q)
        begin
            st_nxt.ddr = RST_DDR;
            st_nxt.dr  = RST_DR;
            st_nxt.pcr = RST_PCR;
        end
        else if (wr_en)
        begin
            if (hit_ddr)
            begin
                st_nxt.ddr = pwdata[PORT_W-1:0];
            end
            else if (hit_dr)
            begin
                st_nxt.dr = pwdata[PORT_W-1:0];
            end
            else if (hit_pcr)
            begin
                st_nxt.pcr = pwdata[PORT_W-1:0];
            end
        end

        if (setup_cyc)
        begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = '0;
            if (hit_ddr)
            begin
                st_nxt.prdata = '0;
            end
            else if (hit_dr)
            begin
                st_nxt.prdata = pwrite ? '0 : dr_view;
            end
            else if (hit_pcr)
            begin
                st_nxt.prdata = pwrite ? '0 : st_r.pcr;
            end
            else if (hit_stat)
            begin
                st_nxt.prdata                            = '0;
                st_nxt.prdata[STAT_MODE_LSB +: MODE_W]   = mode_q;
                st_nxt.prdata[STAT_SWSB_BIT]             = st_r.swsb;
                st_nxt.prdata[STAT_HWSB_BIT]             = st_r.hwsb;
                st_nxt.prdata[STAT_SNGL_BIT]             = st_r.single;
                if (pwrite)
                begin
                    st_nxt.prdata = '0;
                end
            end
            else
            begin
                st_nxt.pslverr = 1'b1;
            end
        end

        if (st_nxt.hwsb)
        begin
            st_nxt.pin_oe  = '0;
            st_nxt.pin_out = '0;
            st_nxt.pin_pu  = '0;
        end
        else if (st_nxt.single)
        begin
            st_nxt.pin_oe  = st_nxt.ddr;
            st_nxt.pin_out = st_nxt.dr;
            st_nxt.pin_pu  = st_nxt.pcr & ~st_nxt.ddr;
        end
        else if (st_nxt.swsb)
        begin
            st_nxt.pin_oe  = '0;
            st_nxt.pin_out = '0;
            st_nxt.pin_pu  = '0;
        end
        else
        begin
            st_nxt.pin_oe  = {PORT_W{bus_doe}};
            st_nxt.pin_out = bus_dout;
            st_nxt.pin_pu  = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= ST_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata     = {{(PDATA_W-PORT_W){1'b0}}, st_r.prdata};
    assign pready     = st_r.pready;
    assign pslverr    = st_r.pslverr;
    assign pin_out    = st_r.pin_out;
    assign pin_oe     = st_r.pin_oe;
    assign pin_pullup = st_r.pin_pu;
    assign bus_din    = pin_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_dir_drives_pins: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.single && !st_r.hwsb) |-> (pin_oe == st_r.ddr && pin_out == st_r.dr))
        else $error("Pin drive does not follow direction and data in single-chip mode.");

    chk_dir_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_cyc && !pwrite && hit_ddr) |=> (pready && prdata == '0))
        else $error("Direction register read did not return zero.");

    chk_data_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_dr && !hw_q) |=> (st_r.dr == $past(pwdata[PORT_W-1:0])))
        else $error("Data register write did not land on the next edge.");

    chk_data_read_mix: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_cyc && !pwrite && hit_dr) |=>
        (prdata[PORT_W-1:0] == (($past(st_r.ddr) & $past(st_r.dr)) | (~$past(st_r.ddr) & $past(pin_q)))))
        else $error("Data read does not mix latch and pin levels by direction.");

    chk_pullup_gate: assert property (@(posedge pclk) disable iff (!presetn)
        pin_pullup == ((st_r.single && !st_r.hwsb) ? (st_r.pcr & ~st_r.ddr) : '0))
        else $error("Pull-up drive disagrees with control, direction and mode.");

    chk_pullup_expanded: assert property (@(posedge pclk) disable iff (!presetn)
        !st_r.single |-> (pin_pullup == '0))
        else $error("Pull-up active outside single-chip mode.");

    chk_bus_mode_pins: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(presetn) && !st_r.single && !st_r.hwsb && !st_r.swsb) |->
        (pin_oe == {PORT_W{$past(bus_doe)}} && pin_out == $past(bus_dout)))
        else $error("Expanded mode pins do not follow the data bus.");

    chk_hw_standby_clear: assert property (@(posedge pclk) disable iff (!presetn)
        st_r.hwsb |-> (st_r.ddr == '0 && st_r.dr == '0 && st_r.pcr == '0 && pin_oe == '0 && pin_pullup == '0))
        else $error("Hardware standby did not clear registers and float pins.");

    chk_sw_standby_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(st_r.swsb) && !st_r.hwsb) |->
        (st_r.ddr == $past(st_r.ddr) && st_r.dr == $past(st_r.dr) && st_r.pcr == $past(st_r.pcr)))
        else $error("Port registers changed during software standby.");

    chk_sw_standby_float: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.swsb && !st_r.single) |-> (pin_oe == '0))
        else $error("Expanded mode pin driven during software standby.");

    chk_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        setup_cyc |=> pready ##1 !pready)
        else $error("APB ready not a single-cycle answer.");

    chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_cyc && !(hit_pcr || hit_ddr || hit_dr || hit_stat)) |=> (pslverr && pready))
        else $error("Unmapped access did not raise an error.");

    chk_dir_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_ddr && !hw_q) |=> (st_r.ddr == $past(pwdata[PORT_W-1:0])))
        else $error("Direction register write did not land on the next edge.");

    chk_dir_write_pins: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_ddr && !hw_q && mode_q == MODE_SINGLE) |=> (pin_oe == $past(pwdata[PORT_W-1:0])))
        else $error("Pin directions did not follow a direction write at once.");

    chk_pcr_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_pcr && !hw_q) |=> (st_r.pcr == $past(pwdata[PORT_W-1:0])))
        else $error("Pull-up control write did not land on the next edge.");

    chk_pcr_read_back: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_cyc && !pwrite && hit_pcr) |=> (prdata[PORT_W-1:0] == $past(st_r.pcr)))
        else $error("Pull-up control read does not return the register.");

    chk_write_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_cyc && pwrite) |=> (prdata == '0))
        else $error("Write access returned non-zero read data.");

    chk_ready_from_setup: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> $past(setup_cyc))
        else $error("APB ready raised without a setup cycle.");

    chk_error_only_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> ($past(setup_cyc) && !$past(hit_pcr) && !$past(hit_ddr) && !$past(hit_dr) && !$past(hit_stat)))
        else $error("Error raised for a mapped address.");

    chk_status_read: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_cyc && !pwrite && hit_stat) |=>
        (prdata[PORT_W-1:0] == {3'h0, $past(st_r.single), $past(st_r.hwsb), $past(st_r.swsb), $past(mode_q)}))
        else $error("Status read does not show mode and standby levels.");

    chk_sw_single_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.swsb && $past(st_r.swsb) && st_r.single && $past(st_r.single) &&
         !st_r.hwsb && !$past(st_r.hwsb)) |->
        ($stable(pin_oe) && $stable(pin_out) && $stable(pin_pullup)))
        else $error("Pin state changed during software standby in single-chip mode.");

    chk_stray_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && !hw_q && !(hit_pcr || hit_ddr || hit_dr)) |=>
        ($stable(st_r.ddr) && $stable(st_r.dr) && $stable(st_r.pcr)))
        else $error("Write to an unmapped or read-only address changed a port register.");

    // ------------------------------------------------------------------
    // Cover properties
    // ------------------------------------------------------------------

    cov_data_write: cover property (@(posedge pclk) disable iff (!presetn) wr_en && hit_dr);
    cov_data_read: cover property (@(posedge pclk) disable iff (!presetn) setup_cyc && !pwrite && hit_dr);
    cov_hw_standby: cover property (@(posedge pclk) disable iff (!presetn) !st_r.hwsb ##1 st_r.hwsb);
    cov_sw_single: cover property (@(posedge pclk) disable iff (!presetn) st_r.swsb && st_r.single && pin_oe != '0);
    cov_sw_expanded: cover property (@(posedge pclk) disable iff (!presetn) st_r.swsb && !st_r.single);

endmodule

`default_nettype wire

// >>> dv/sdp_pin_model.sv
// Pin model: the eight external pads of the port and whatever drives them from outside.
// Assumes the bench sets the outside drive; undriven pads with no pull-up wander every cycle.
`timescale 1ns/1ps
`default_nettype none

module sdp_pin_model (
    input  wire logic       pclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    logic [7:0] wander = 8'h00;

    // ------------------------------------------------------------------
    // Pad level
    // ------------------------------------------------------------------
    // A floating pad toggles so that no stale level can be read back.
    always @(posedge pclk) wander <= ~wander;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup[i] ? 1'b1 : wander[i];
    end
endmodule

`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the shared data bus I/O port.
// Assumes the design package and a pin model; APB master on pclk.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import sdp_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata;
    logic        pready, pslverr;
    logic [1:0]  mode_pins = 2'h1;
    logic        hw_standby_n = 1'b1, sw_standby = 1'b0, bus_doe = 1'b0;
    logic [7:0]  bus_dout = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0]  bus_din, pin_in, pin_out, pin_oe, pin_pullup;
    logic [31:0] rd;
    logic        er;
    int          miscompares = 0, n_checks = 0;

    always #50 pclk = ~pclk;

    sdp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode_pins(mode_pins), .hw_standby_n(hw_standby_n), .sw_standby(sw_standby), .bus_dout(bus_dout),
        .bus_doe(bus_doe), .bus_din(bus_din), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup));
    sdp_pin_model pads (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] d, input logic [3:0] st);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic pins(input logic [7:0] oe, input logic [7:0] o, input logic [7:0] pu, input string what);
        chk({24'h0, pin_oe}, {24'h0, oe}, what);
        chk({24'h0, pin_out}, {24'h0, o}, what);
        chk({24'h0, pin_pullup}, {24'h0, pu}, what);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        wrap_up();
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        pins(8'h00, 8'h00, 8'h00, "pins in reset");
        apb(1'b0, ADDR_PCR, 8'h00, 4'hF);
        chk(rd, 32'h0, "pcr reset");
        apb(1'b0, ADDR_DDR, 8'h00, 4'hF);
        chk(rd, 32'h0, "ddr not readable");
        @(posedge pclk);
        mode_pins <= MODE_SINGLE;
        ext_en <= 8'h03; ext_val <= 8'h02;
        settle(4);
        pins(8'h00, 8'h00, 8'h00, "ddr reset input");
        apb(1'b1, ADDR_DDR, 8'hF0, 4'hF);
        apb(1'b1, ADDR_DR, 8'hA5, 4'hF);
        apb(1'b1, ADDR_PCR, 8'h3C, 4'hF);
        @(negedge pclk);
        pins(8'hF0, 8'hA5, 8'h0C, "single chip pins");
        settle(3);
        apb(1'b0, ADDR_DR, 8'h00, 4'hF);
        chk(rd, 32'hAE, "dr latch and pin mix");
        apb(1'b0, ADDR_PCR, 8'h00, 4'hF);
        chk(rd, 32'h3C, "pcr readback");
        apb(1'b0, ADDR_STAT, 8'h00, 4'hF);
        chk(rd, 32'h13, "status single chip");
        apb(1'b1, ADDR_DR, 8'h00, 4'h0);
        apb(1'b0, 18'h00004, 8'h00, 4'hF);
        chk({31'h0, er}, 32'h1, "unmapped error");
        @(negedge pclk);
        chk({24'h0, pin_out}, 32'hA5, "masked write ignored");
        @(posedge pclk);
        sw_standby <= 1'b1;
        settle(2);
        apb(1'b1, ADDR_DR, 8'h00, 4'hF);
        settle(2);
        pins(8'hF0, 8'hA5, 8'h0C, "sw standby single chip");
        @(posedge pclk);
        sw_standby <= 1'b0;
        for (int m = 1; m <= 2; m++)
        begin
            @(posedge pclk);
            mode_pins <= m[1:0];
            bus_doe <= 1'b1; bus_dout <= 8'h5A;
            settle(5);
            pins(8'hFF, 8'h5A, 8'h00, "expanded drives bus");
            chk({24'h0, bus_din}, 32'h5A, "bus_din drive");
            @(posedge pclk);
            bus_doe <= 1'b0; ext_en <= 8'hFF; ext_val <= 8'hC3;
            settle(4);
            pins(8'h00, 8'h5A, 8'h00, "expanded input");
            chk({24'h0, bus_din}, 32'hC3, "bus_din input");
            @(posedge pclk);
            bus_doe <= 1'b1; sw_standby <= 1'b1;
            settle(3);
            pins(8'h00, 8'h00, 8'h00, "sw standby expanded");
            apb(1'b0, ADDR_STAT, 8'h00, 4'hF);
            chk(rd, 32'h4 | m, "status sw standby");
            @(posedge pclk);
            sw_standby <= 1'b0; ext_en <= 8'h03; ext_val <= 8'h02;
        end
        @(posedge pclk);
        mode_pins <= MODE_SINGLE;
        settle(4);
        pins(8'hF0, 8'hA5, 8'h0C, "registers kept across modes");
        @(posedge pclk);
        hw_standby_n <= 1'b0;
        settle(4);
        pins(8'h00, 8'h00, 8'h00, "hw standby pins");
        @(posedge pclk);
        hw_standby_n <= 1'b1;
        settle(4);
        apb(1'b0, ADDR_PCR, 8'h00, 4'hF);
        chk(rd, 32'h0, "hw standby clears pcr");
        apb(1'b1, ADDR_DDR, 8'h0F, 4'hF);
        apb(1'b1, ADDR_DR, 8'h33, 4'hF);
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        pins(8'h00, 8'h00, 8'h00, "async reset pins");
        @(posedge pclk);
        presetn <= 1'b1;
        settle(4);
        pins(8'h00, 8'h00, 8'h00, "registers cleared by reset");
        wrap_up();
    end
endmodule

`default_nettype wire
